//--- rtl/tmc_defs.svh
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
// register offsets (4-bit address port)
`define TMC_ADR_CONTROL 4'h0
`define TMC_ADR_COUNT 4'h1
`define TMC_ADR_FLAGS 4'h2
`define TMC_ADR_MASK 4'h3
`define TMC_ADR_IRQ_STATUS 4'h4
`define TMC_ADR_IRQ_CLEAR 4'h5
`define TMC_ADR_IRQ_ENABLE 4'h6
`define TMC_ADR_GLOBAL 4'h7
// field positions
`define TMC_CS_MSB 2
`define TMC_OVF_BIT 1
`define TMC_TOIE_BIT 1
`define TMC_GIE_BIT 7
`define TMC_IRQ_OVF_BIT 0
// clock select codes
`define TMC_CS_STOP 3'h0
`define TMC_CS_DIV1 3'h1
`define TMC_CS_DIV8 3'h2
`define TMC_CS_DIV64 3'h3
`define TMC_CS_DIV256 3'h4
`define TMC_CS_DIV1024 3'h5
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7
// prescaler taps: bit index of the 10-bit chain whose carry marks the tick
`define TMC_PRE_W 10
`define TMC_TAP8 3'h2
`define TMC_TAP64 3'h5
`define TMC_TAP256 3'h7
`define TMC_TAP1024 4'h9
// reset values and the count limit
`define TMC_RST_BYTE 8'h00
`define TMC_RST_PRE 10'h000
`define TMC_CNT_MAX 8'hff
`endif

//--- rtl/tmc_pkg.sv
package tmc_pkg;
   typedef logic [7:0] tmc_byte_t;
   typedef logic [2:0] tmc_sel_t;
endpackage : tmc_pkg

//--- rtl/tmc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_sync (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tmc_sync_st_t;
   tmc_sync_st_t st_ff, nxt_st;
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // a change counts only once stages two and three agree
      if (st_ff.s2 == st_ff.s3) begin
         nxt_st.lvl = st_ff.s3;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   always_comb begin
      level_o = st_ff.lvl;
      rise_o = (st_ff.s2 == st_ff.s3) && st_ff.s3 && !st_ff.lvl;
      fall_o = (st_ff.s2 == st_ff.s3) && !st_ff.s3 && st_ff.lvl;
   end
endmodule : tmc_sync
`default_nettype wire

//--- rtl/tmc_timer.sv
// What this block does
// [R1] one 8-bit counter fed through a shared 10-bit divider chain on the oscillator clock.
// [R2] the chain offers ticks at divide by 8, 64, 256 and 1024, all from the undivided clock.
// [R3] clock select bits 2..0 of control choose the source; zero stops, one is the raw clock.
// [R4] select values two to five count on the divide by 8, 64, 256 and 1024 ticks.
// [R5] select six counts falling edges of the count pin, seven counts its rising edges.
// [R6] the count pin is sampled on the rising system clock before edges are detected.
// [R7] the source on the count pin keeps at least two clock periods between transitions; the synchronizer needs each level held two clocks.
// [R8] software makes the count pin an input before choosing an external mode.
// [R9] the counter adds one per selected event and software reads and writes it.
// [R10] after a write to the count, counting resumes from that value at the next tick.
// [R11] incrementing from 0xff wraps to 0x00, which is the overflow event.
// [R12] overflow sets the overflow flag; taking the vector or writing a one clears it.
// [R13] the overflow request at vector 0x002 needs flag, enable and global enable set.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_defs.svh"
module tmc_timer (
   input wire logic CLK_SYS_I,
   input wire logic RSTN_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic COUNT_PIN_I,
   input wire logic VECTOR_TAKEN_I,
   output logic OVF_REQ_O,
   output logic [11:0] OVF_VECTOR_O,
   output logic IRQ_O
);
   localparam logic [11:0] OVF_VECTOR = 12'h002;
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      tmc_pkg::tmc_sel_t sel;
      tmc_pkg::tmc_byte_t count;
      logic [`TMC_PRE_W-1:0] pre;
      logic ovf_flag;
      logic toie;
      logic gie;
      logic irq_sts;
      logic irq_en;
      tmc_pkg::tmc_byte_t rdata;
      logic req;
      logic irq;
   } tmc_st_t;
   tmc_st_t st_ff, nxt_st;
   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic tick;
   logic ovf_evt;
   logic [`TMC_PRE_W-1:0] pre_inc;
   ////////////////////////////////////////////////////////////////////////////////
   tmc_sync u_sync ( // [R6]
      .clk_i(CLK_SYS_I),
      .rstn_i(RSTN_I),
      .pin_i(COUNT_PIN_I),
      .level_o(pin_level),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );
   // tick when all bits up to the tap are ones, i.e. once per 2**(tap+1) clocks
   function automatic logic tap_hit(input logic [`TMC_PRE_W-1:0] pre, input int tap);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i < `TMC_PRE_W; i++) begin
         if (i <= tap && !pre[i]) begin
            hit = 1'b0;
         end
      end
      return hit;
   endfunction : tap_hit
   function automatic tmc_pkg::tmc_byte_t reg_rd(input tmc_st_t s, input logic [3:0] a);
      tmc_pkg::tmc_byte_t d;
      d = `TMC_RST_BYTE;
      case (a)
         `TMC_ADR_CONTROL: d = {5'h00, s.sel};
         `TMC_ADR_COUNT: d = s.count;
         `TMC_ADR_FLAGS: d[`TMC_OVF_BIT] = s.ovf_flag;
         `TMC_ADR_MASK: d[`TMC_TOIE_BIT] = s.toie;
         `TMC_ADR_IRQ_STATUS: d[`TMC_IRQ_OVF_BIT] = s.irq_sts;
         `TMC_ADR_IRQ_ENABLE: d[`TMC_IRQ_OVF_BIT] = s.irq_en;
         `TMC_ADR_GLOBAL: d[`TMC_GIE_BIT] = s.gie;
         default: d = `TMC_RST_BYTE;
      endcase
      return d;
   endfunction : reg_rd
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      pre_inc = st_ff.pre + 10'h001; // [R1]
      case (st_ff.sel) // [R3] [R4] [R5]
         `TMC_CS_STOP: tick = 1'b0;
         `TMC_CS_DIV1: tick = 1'b1;
         `TMC_CS_DIV8: tick = tap_hit(st_ff.pre, `TMC_TAP8); // [R2]
         `TMC_CS_DIV64: tick = tap_hit(st_ff.pre, `TMC_TAP64);
         `TMC_CS_DIV256: tick = tap_hit(st_ff.pre, `TMC_TAP256);
         `TMC_CS_DIV1024: tick = tap_hit(st_ff.pre, `TMC_TAP1024);
         `TMC_CS_EXT_FALL: tick = pin_fall;
         `TMC_CS_EXT_RISE: tick = pin_rise;
         default: tick = 1'b0;
      endcase
   end
   always_comb begin
      nxt_st = st_ff;
      ovf_evt = 1'b0;
      nxt_st.pre = pre_inc; // free-running so all taps stay phase-aligned
      // a count write takes this cycle; the tick is lost so counting resumes on the next one
      if (WR_I && ADDR_I == `TMC_ADR_COUNT) begin
         nxt_st.count = WDATA_I; // [R9] [R10]
      end else if (tick) begin
         nxt_st.count = st_ff.count + 8'h01; // [R9] [R11]
         ovf_evt = (st_ff.count == `TMC_CNT_MAX); // [R11]
      end
      if (WR_I) begin
         case (ADDR_I)
            `TMC_ADR_CONTROL: nxt_st.sel = WDATA_I[`TMC_CS_MSB:0]; // [R3]
            `TMC_ADR_FLAGS: if (WDATA_I[`TMC_OVF_BIT]) nxt_st.ovf_flag = 1'b0; // [R12]
            `TMC_ADR_MASK: nxt_st.toie = WDATA_I[`TMC_TOIE_BIT];
            `TMC_ADR_IRQ_CLEAR: if (WDATA_I[`TMC_IRQ_OVF_BIT]) nxt_st.irq_sts = 1'b0;
            `TMC_ADR_IRQ_ENABLE: nxt_st.irq_en = WDATA_I[`TMC_IRQ_OVF_BIT];
            `TMC_ADR_GLOBAL: nxt_st.gie = WDATA_I[`TMC_GIE_BIT];
            default: nxt_st.sel = st_ff.sel;
         endcase
      end
      if (VECTOR_TAKEN_I) begin
         nxt_st.ovf_flag = 1'b0; // [R12]
      end
      // set wins over either clear
      if (ovf_evt) begin
         nxt_st.ovf_flag = 1'b1; // [R12]
         nxt_st.irq_sts = 1'b1;
      end
      nxt_st.req = nxt_st.ovf_flag && nxt_st.toie && nxt_st.gie; // [R13]
      nxt_st.irq = nxt_st.irq_sts && nxt_st.irq_en;
      nxt_st.rdata = RD_I ? reg_rd(st_ff, ADDR_I) : `TMC_RST_BYTE;
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (!RSTN_I) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   always_comb begin
      RDATA_O = st_ff.rdata;
      OVF_REQ_O = st_ff.req;
      IRQ_O = st_ff.irq;
   end
   // constant vector, loaded by a register with no reset, so it is unknown until the first clock
   always_ff @(posedge CLK_SYS_I) begin
      OVF_VECTOR_O <= OVF_VECTOR; // [R13]
   end
   ////////////////////////////////////////////////////////////////////////////////
   stop_holds_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R3]
      (st_ff.sel == `TMC_CS_STOP && !WR_I) |=> $stable(st_ff.count))
      else $error("counter moved while stopped");
   div1_inc_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R3]
      (st_ff.sel == `TMC_CS_DIV1 && !WR_I) |=> st_ff.count == $past(st_ff.count) + 8'h01)
      else $error("raw clock mode did not count");
   div8_rate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R2]
      (st_ff.sel == `TMC_CS_DIV8 && st_ff.pre[2:0] != 3'h7) |-> !tick)
      else $error("divide by 8 ticked off phase");
   div1024_rate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R4]
      (st_ff.sel == `TMC_CS_DIV1024 && tick) |-> st_ff.pre == 10'h3ff)
      else $error("divide by 1024 ticked off phase");
   ext_rise_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R5]
      (st_ff.sel == `TMC_CS_EXT_RISE && tick) |=> pin_level)
      else $error("rising mode counted a falling edge");
   write_load_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R10]
      (WR_I && ADDR_I == `TMC_ADR_COUNT) |=> st_ff.count == $past(WDATA_I))
      else $error("count write not loaded");
   wrap_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R11]
      (tick && !WR_I && st_ff.count == 8'hff) |=> (st_ff.count == 8'h00 && st_ff.ovf_flag))
      else $error("wrap did not set flag");
   flag_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R12]
      (VECTOR_TAKEN_I && !ovf_evt) |=> !st_ff.ovf_flag)
      else $error("vector did not clear flag");
   req_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R13]
      OVF_REQ_O |-> (st_ff.ovf_flag && st_ff.toie && st_ff.gie))
      else $error("request without all enables");
   pre_step_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R1]
      1'b1 |=> st_ff.pre == $past(st_ff.pre) + 10'h001)
      else $error("prescaler did not step");
   ext_fall_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R5]
      (st_ff.sel == `TMC_CS_EXT_FALL && tick) |=> !pin_level)
      else $error("falling mode counted a rising edge");
   irq_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) // [R12]
      IRQ_O |-> (st_ff.irq_sts && st_ff.irq_en))
      else $error("interrupt without status and enable");
endmodule : tmc_timer
`default_nettype wire

//--- testbench/tmc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tmc_pin_model (
   input wire logic clk_i,
   output logic pin_o
);
   initial pin_o = 1'b0;
   // each level held four clocks, more than the two the pin needs
   task automatic step(input logic lvl);
      repeat (4) @(posedge clk_i);
      pin_o <= lvl;
   endtask : step
endmodule : tmc_pin_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "tmc_defs.svh"
module tb;
   logic clk, rstn, wr, rd, vt, pin, ovf_req, irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic [11:0] ovf_vec;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   tmc_timer uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .COUNT_PIN_I(pin), .VECTOR_TAKEN_I(vt),
      .OVF_REQ_O(ovf_req), .OVF_VECTOR_O(ovf_vec), .IRQ_O(irq));
   tmc_pin_model pm (.clk_i(clk), .pin_o(pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   // whole run needs about 4.2k cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobe stays up until the next task or idle edge, so writes may run back to back
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
   endtask : wr_reg
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask : idle
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({4'h0, rdata}, {4'h0, exp});
   endtask : rd_reg
   // write ff then stop one cycle later: the tick of that cycle wraps it
   task automatic ovf();
      wr_reg(`TMC_ADR_CONTROL, 8'h01);
      wr_reg(`TMC_ADR_COUNT, 8'hff);
      wr_reg(`TMC_ADR_CONTROL, 8'h00);
   endtask : ovf
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      wr_reg(4'h9, 8'hff);
      for (int a = 0; a < 10; a++) rd_reg(4'(a), 8'h00);
      chk(ovf_vec, 12'h002);
      $display("reset test done");
   endtask : t_reset
   // a window of exactly 3*div cycles holds three ticks whatever the phase
   task automatic t_taps();
      int div [5] = '{1, 8, 64, 256, 1024};
      for (int i = 0; i < 5; i++) begin
         wr_reg(`TMC_ADR_COUNT, 8'h00);
         wr_reg(`TMC_ADR_CONTROL, {5'h1f, 3'(i + 1)});
         idle(3 * div[i] - 3);
         rd_reg(`TMC_ADR_CONTROL, 8'(i + 1));
         wr_reg(`TMC_ADR_CONTROL, 8'h00);
         rd_reg(`TMC_ADR_COUNT, 8'h03);
      end
      $display("tap test done");
   endtask : t_taps
   task automatic t_count();
      wr_reg(`TMC_ADR_CONTROL, 8'h01);
      wr_reg(`TMC_ADR_COUNT, 8'h80);
      wr_reg(`TMC_ADR_CONTROL, 8'h00);
      rd_reg(`TMC_ADR_COUNT, 8'h81);
      rd_reg(`TMC_ADR_FLAGS, 8'h00);
      ovf();
      rd_reg(`TMC_ADR_COUNT, 8'h00);
      rd_reg(`TMC_ADR_FLAGS, 8'h02);
      wr_reg(`TMC_ADR_FLAGS, 8'h02);
      rd_reg(`TMC_ADR_FLAGS, 8'h00);
      $display("count test done");
   endtask : t_count
   task automatic t_irq();
      ovf();
      idle(2);
      chk(irq, 1'b0);
      wr_reg(`TMC_ADR_IRQ_ENABLE, 8'h01);
      idle(2);
      chk(irq, 1'b1);
      wr_reg(`TMC_ADR_IRQ_CLEAR, 8'h01);
      idle(2);
      chk(irq, 1'b0);
      rd_reg(`TMC_ADR_IRQ_STATUS, 8'h00);
      wr_reg(`TMC_ADR_MASK, 8'h02);
      idle(2);
      chk(ovf_req, 1'b0);
      wr_reg(`TMC_ADR_GLOBAL, 8'h80);
      idle(2);
      chk(ovf_req, 1'b1);
      @(posedge clk);
      vt <= 1'b1;
      @(posedge clk);
      vt <= 1'b0;
      idle(2);
      chk(ovf_req, 1'b0);
      rd_reg(`TMC_ADR_FLAGS, 8'h00);
      $display("irq test done");
   endtask : t_irq
   // falling mode counts nothing on the rise, rising mode counts it at once
   task automatic t_pin();
      for (int e = 0; e < 2; e++) begin
         wr_reg(`TMC_ADR_COUNT, 8'h00);
         wr_reg(`TMC_ADR_CONTROL, 8'(6 + e));
         idle(8);
         pm.step(1'b1);
         idle(8);
         rd_reg(`TMC_ADR_COUNT, 8'(e));
         pm.step(1'b0);
         idle(8);
         rd_reg(`TMC_ADR_COUNT, 8'h01);
      end
      $display("pin test done");
   endtask : t_pin
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      vt = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_taps();
      t_count();
      t_irq();
      t_pin();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
